// *** hdl/core_sfr_defines.svh ***
/*
  Offsets, bit positions and reset values of the core special register bank.
  Assumes inclusion by bare name from the design modules and the bench.
*/
`ifndef CORE_SFR_DEFINES_SVH
`define CORE_SFR_DEFINES_SVH

// ==========================================================
// Register offsets
`define OFF_INDIRECT_ACCESS_PORT 6'h00
`define OFF_TIMER0_COUNT         6'h01
`define OFF_PC_LOW_BYTE          6'h02
`define OFF_STATUS_FLAGS         6'h03
`define OFF_FILE_SELECT          6'h04
`define OFF_PORT_B_DATA          6'h06
`define OFF_POWER_CONTROL        6'h08
`define OFF_PORT_WAKE_CONTROL    6'h09
`define OFF_PC_HIGH_BUFFER       6'h0A

// ==========================================================
// Field positions
`define BIT_CARRY            0
`define BIT_HALF_CARRY       1
`define BIT_ZERO             2
`define BIT_POWER_DOWN       3
`define BIT_TIMEOUT          4
`define BIT_WATCHDOG_EN      7
`define BIT_EXT_INT_SEL      6
`define BIT_LV_DETECT_EN     5
`define BIT_LV_RESET_EN      3
`define HALF_CARRY_POS       4

// ==========================================================
// Reset values
`define RST_STATUS_FLAGS     8'h18
`define RST_FILE_SELECT      8'h00
`define RST_POWER_CONTROL    8'h88
`define RST_WAKE_CONTROL     6'h3F
`define RST_PC_HIGH_BUFFER   3'h0
`define RST_PC               10'h000
`define RST_TIMER0           8'h00
`define RST_PORT_LATCH       6'h00

`endif

// *** hdl/core_sfr_pkg.sv ***
/*
  Types shared by the core special register bank and its flag unit.
  Assumes the defines header is on the include path.
*/
package core_sfr_pkg;

  // ==========================================================
  // Program counter commands from the core
  typedef enum logic [2:0] {
    PC_HOLD        = 3'h0,
    PC_STEP        = 3'h1,
    PC_SHORT_JUMP  = 3'h2,
    PC_SHORT_CALL  = 3'h3,
    PC_LONG_JUMP   = 3'h4,
    PC_LONG_CALL   = 3'h5,
    PC_RETURN      = 3'h6
  } pc_op_t;

  // ==========================================================
  // Arithmetic flag update kinds
  typedef enum logic [1:0] {
    FLAG_NONE  = 2'h0,
    FLAG_ADD   = 2'h1,
    FLAG_SUB   = 2'h2,
    FLAG_LOGIC = 2'h3
  } flag_op_t;

  // ==========================================================
  // Whole state of the bank
  typedef struct packed {
    logic [9:0] pc;
    logic [7:0] tmr;
    logic [7:0] status;
    logic [7:0] file_select;
    logic [5:0] latch;
    logic [1:0] pb_gp;
    logic [7:0] power_control;
    logic [5:0] wake;
    logic [2:0] pc_high_buffer;
    logic ext_prev;
    logic lf_prev;
    logic [7:0] rd_data;
    logic push_valid;
    logic [9:0] push_addr;
  } bank_state_t;

endpackage : core_sfr_pkg

// *** hdl/core_special_register_bank.sv ***
/*
  Core special register bank: indirect port, timer0 count, program counter,
  status flags, file select, port B data, power control, wake-up and PC high buffer.
  Assumes a core that issues one data access and one PC command per enabled cycle,
  with all inputs synchronous to i_clk.
*/
// Overview of operation
// - Accesses to the indirect port go to the register chosen by file select.
// - Timer0 count reads the live count; a write replaces the count at once.
// - Timer0 counts instruction ticks, external pin edges or low-frequency edges.
// - PC low byte mirrors PC bits 7..0; PC steps by one on a step command unless loaded.
// - On short call and low-byte write, PC bits 9..8 come from the staged high buffer.
// - Short jump: PC 8..0 from instruction, bit 9 from buffer bit 1.
// - Short call: PC 7..0 from instruction, 9..8 from buffer; push PC+1.
// - Long jump and long call load all ten bits; long call pushes PC+1.
// - Carry is set on add carry or on subtract without borrow.
// - Half carry is the same but out of the fourth bit.
// - Zero flag is set when the result is zero.
// - Power-down flag: one after reset or watchdog clear, zero after sleep.
// - Timeout flag: one after reset, watchdog clear or sleep; zero on timeout.
// - Status bits 7..5 are plain storage, reset to zero.
// - File select bits 5..0 pick one of 64 registers for indirect access.
// - File select bank bits are stored but have no addressing effect.
// - Port B reads pins, or latches for outputs when the read option asks.
// - Port B writes load output latches; top two bits are storage.
// - Power control: watchdog, low-voltage detect and reset enables, bit 6 routing; others storage.
// - Power control bit 6 routes port B pin 0 to the external interrupt.
// - Wake control bits 5..0 enable wake-up per pin, reset to one.
// - PC high buffer holds staged PC bits 9..8 and one storage bit.
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.svh"

module core_special_register_bank #(
  parameter int ADDR_W = 6
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Core data access
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_rd_en,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  // General register file outside the bank
  output logic o_gpr_sel,
  output logic [ADDR_W-1:0] o_gpr_addr,
  output logic o_gpr_we,
  output logic [7:0] o_gpr_wdata,
  input wire logic [7:0] i_gpr_rdata,
  // Program counter control
  input wire core_sfr_pkg::pc_op_t i_pc_op,
  input wire logic [9:0] i_insn_target,
  input wire logic [9:0] i_ret_addr,
  output logic [9:0] o_pc,
  output logic o_push_valid,
  output logic [9:0] o_push_addr,
  // Arithmetic flag update
  input wire core_sfr_pkg::flag_op_t i_flag_op,
  input wire logic [7:0] i_opnd_a,
  input wire logic [7:0] i_opnd_b,
  input wire logic [7:0] i_logic_result,
  // Power events
  input wire logic i_sleep,
  input wire logic i_clrwdt,
  input wire logic i_wdt_timeout,
  // Timer0 sources and mode
  input wire logic i_inst_tick,
  input wire logic i_ext_timer_clk,
  input wire logic i_lowfreq_clk,
  input wire logic i_t0_ext_src,
  input wire logic i_t0_lowfreq_sel,
  input wire logic i_t0_fall_edge,
  input wire logic i_cfg_lowfreq_allow,
  output logic [7:0] o_timer0,
  // Port B
  input wire logic [5:0] i_pin_level,
  input wire logic [5:0] i_pin_is_output,
  input wire logic i_cfg_read_latch,
  output logic [5:0] o_port_latch,
  // Power and wake controls
  output logic o_watchdog_enable,
  output logic o_lv_detect_enable,
  output logic o_lv_reset_enable,
  output logic o_ext_int_route,
  output logic [5:0] o_wake_enable
);
  import core_sfr_pkg::*;

  // ==========================================================
  // Parameter check
  generate
    if (ADDR_W != 6) begin : g_bad_addr_w
      $error("ADDR_W must be 6: file select indexes 64 registers");
    end
  endgenerate

  localparam bank_state_t RST_STATE = '{
    pc: `RST_PC, tmr: `RST_TIMER0, status: `RST_STATUS_FLAGS,
    file_select: `RST_FILE_SELECT, latch: `RST_PORT_LATCH, pb_gp: 2'h0,
    power_control: `RST_POWER_CONTROL, wake: `RST_WAKE_CONTROL,
    pc_high_buffer: `RST_PC_HIGH_BUFFER, ext_prev: 1'b0, lf_prev: 1'b0,
    rd_data: 8'h00, push_valid: 1'b0, push_addr: 10'h000};

  bank_state_t st_ff;
  bank_state_t nxt_st;
  logic [5:0] eff_addr;
  logic bank_hit;
  logic [7:0] rd_mux;
  logic [5:0] port_read;
  logic src_edge;
  logic ext_edge;
  logic lf_edge;
  logic pcl_wr;
  logic upd_arith;
  logic upd_zero;
  logic f_carry;
  logic f_half;
  logic f_zero;

  // ==========================================================
  // Flag unit
  sfr_flag_unit u_flags (
    .i_op(i_flag_op),
    .i_opnd_a(i_opnd_a),
    .i_opnd_b(i_opnd_b),
    .i_logic_result(i_logic_result),
    .o_update_arith(upd_arith),
    .o_update_zero(upd_zero),
    .o_carry(f_carry),
    .o_half_carry(f_half),
    .o_zero(f_zero)
  );

  // ==========================================================
  // Address decode and read mux
  always_comb begin
    // Bank bits 7..6 are not part of the address; one bank only
    eff_addr = (i_addr == `OFF_INDIRECT_ACCESS_PORT) ? st_ff.file_select[5:0] : i_addr;
    for (int i = 0; i < 6; i++) begin
      port_read[i] = (i_pin_is_output[i] && i_cfg_read_latch) ? st_ff.latch[i] : i_pin_level[i];
    end
    bank_hit = 1'b1;
    case (eff_addr)
      // Indirect through itself reads zero and writes nothing
      `OFF_INDIRECT_ACCESS_PORT: rd_mux = 8'h00;
      `OFF_TIMER0_COUNT: rd_mux = st_ff.tmr;
      `OFF_PC_LOW_BYTE: rd_mux = st_ff.pc[7:0];
      `OFF_STATUS_FLAGS: rd_mux = st_ff.status;
      `OFF_FILE_SELECT: rd_mux = st_ff.file_select;
      `OFF_PORT_B_DATA: rd_mux = {st_ff.pb_gp, port_read};
      `OFF_POWER_CONTROL: rd_mux = st_ff.power_control;
      `OFF_PORT_WAKE_CONTROL: rd_mux = {2'h0, st_ff.wake};
      `OFF_PC_HIGH_BUFFER: rd_mux = {5'h00, st_ff.pc_high_buffer};
      default: begin
        bank_hit = 1'b0;
        rd_mux = i_gpr_rdata;
      end
    endcase
  end

  // Forwarded so indirect access reaches general registers as well
  assign o_gpr_sel = !bank_hit && (i_rd_en || i_wr_en);
  assign o_gpr_addr = eff_addr;
  assign o_gpr_we = !bank_hit && i_wr_en && i_ce;
  assign o_gpr_wdata = i_wr_data;

  // ==========================================================
  // Timer0 source selection
  always_comb begin
    ext_edge = i_t0_fall_edge ? (st_ff.ext_prev && !i_ext_timer_clk)
                              : (!st_ff.ext_prev && i_ext_timer_clk);
    lf_edge = i_t0_fall_edge ? (st_ff.lf_prev && !i_lowfreq_clk)
                             : (!st_ff.lf_prev && i_lowfreq_clk);
    if (!i_t0_ext_src) begin
      src_edge = i_inst_tick;
    end else if (i_t0_lowfreq_sel && i_cfg_lowfreq_allow) begin
      src_edge = lf_edge;
    end else begin
      src_edge = ext_edge;
    end
  end

  assign pcl_wr = i_wr_en && (eff_addr == `OFF_PC_LOW_BYTE);

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_prev = i_ext_timer_clk;
    nxt_st.lf_prev = i_lowfreq_clk;
    nxt_st.push_valid = 1'b0;
    if (i_rd_en) begin
      nxt_st.rd_data = rd_mux;
    end
    // Timer counts unless software overwrites it in the same cycle
    if (src_edge) begin
      nxt_st.tmr = st_ff.tmr + 8'h01;
    end
    if (i_wr_en) begin
      case (eff_addr)
        `OFF_TIMER0_COUNT: nxt_st.tmr = i_wr_data;
        `OFF_STATUS_FLAGS: nxt_st.status = i_wr_data;
        `OFF_FILE_SELECT: nxt_st.file_select = i_wr_data;
        `OFF_PORT_B_DATA: begin
          nxt_st.latch = i_wr_data[5:0];
          nxt_st.pb_gp = i_wr_data[7:6];
        end
        `OFF_POWER_CONTROL: nxt_st.power_control = i_wr_data;
        `OFF_PORT_WAKE_CONTROL: nxt_st.wake = i_wr_data[5:0];
        `OFF_PC_HIGH_BUFFER: nxt_st.pc_high_buffer = i_wr_data[2:0];
        default: begin
        end
      endcase
    end
    // Hardware flag updates win over a software write in the same cycle
    if (upd_arith) begin
      nxt_st.status[`BIT_CARRY] = f_carry;
      nxt_st.status[`BIT_HALF_CARRY] = f_half;
    end
    if (upd_zero) begin
      nxt_st.status[`BIT_ZERO] = f_zero;
    end
    if (i_clrwdt || i_sleep) begin
      nxt_st.status[`BIT_TIMEOUT] = 1'b1;
    end
    if (i_clrwdt) begin
      nxt_st.status[`BIT_POWER_DOWN] = 1'b1;
    end
    if (i_sleep) begin
      nxt_st.status[`BIT_POWER_DOWN] = 1'b0;
    end
    // A timeout is a real event and must not be masked by a clear
    if (i_wdt_timeout) begin
      nxt_st.status[`BIT_TIMEOUT] = 1'b0;
    end
    // Program counter
    case (i_pc_op)
      PC_STEP: nxt_st.pc = st_ff.pc + 10'h001;
      PC_SHORT_JUMP: nxt_st.pc = {st_ff.pc_high_buffer[1], i_insn_target[8:0]};
      PC_SHORT_CALL: begin
        nxt_st.pc = {st_ff.pc_high_buffer[1:0], i_insn_target[7:0]};
        nxt_st.push_valid = 1'b1;
        nxt_st.push_addr = st_ff.pc + 10'h001;
      end
      PC_LONG_JUMP: nxt_st.pc = i_insn_target;
      PC_LONG_CALL: begin
        nxt_st.pc = i_insn_target;
        nxt_st.push_valid = 1'b1;
        nxt_st.push_addr = st_ff.pc + 10'h001;
      end
      PC_RETURN: nxt_st.pc = i_ret_addr;
      default: begin
      end
    endcase
    // Writing the low byte loads the counter; the top bits come from the buffer
    if (pcl_wr) begin
      nxt_st.pc = {st_ff.pc_high_buffer[1:0], i_wr_data};
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= RST_STATE;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rd_data = st_ff.rd_data;
  assign o_pc = st_ff.pc;
  assign o_push_valid = st_ff.push_valid;
  assign o_push_addr = st_ff.push_addr;
  assign o_timer0 = st_ff.tmr;
  assign o_port_latch = st_ff.latch;
  assign o_watchdog_enable = st_ff.power_control[`BIT_WATCHDOG_EN];
  assign o_lv_detect_enable = st_ff.power_control[`BIT_LV_DETECT_EN];
  assign o_lv_reset_enable = st_ff.power_control[`BIT_LV_RESET_EN];
  assign o_ext_int_route = st_ff.power_control[`BIT_EXT_INT_SEL];
  assign o_wake_enable = st_ff.wake;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_INDIRECT_WRITE: assert property (
    i_ce && i_wr_en && i_addr == `OFF_INDIRECT_ACCESS_PORT && st_ff.file_select[5:0] == `OFF_TIMER0_COUNT
    |=> o_timer0 == $past(i_wr_data))
    else $error("indirect write missed timer0");
  AST_TIMER_WRITE: assert property (
    i_ce && i_wr_en && i_addr == `OFF_TIMER0_COUNT |=> o_timer0 == $past(i_wr_data))
    else $error("timer0 write not applied");
  AST_TIMER_TICK: assert property (
    i_ce && !i_t0_ext_src && i_inst_tick && !(i_wr_en && eff_addr == `OFF_TIMER0_COUNT)
    |=> o_timer0 == $past(o_timer0) + 8'h01)
    else $error("timer0 did not count instruction tick");
  AST_PC_STEP: assert property (
    i_ce && i_pc_op == PC_STEP && !pcl_wr |=> o_pc == $past(o_pc) + 10'h001)
    else $error("pc did not step");
  AST_PCL_READ: assert property (
    i_ce && i_rd_en && i_addr == `OFF_PC_LOW_BYTE |=> o_rd_data == $past(o_pc[7:0]))
    else $error("pc low byte read wrong");
  AST_SHORT_JUMP: assert property (
    i_ce && i_pc_op == PC_SHORT_JUMP && !pcl_wr
    |=> o_pc == {$past(st_ff.pc_high_buffer[1]), $past(i_insn_target[8:0])})
    else $error("short jump target wrong");
  AST_SHORT_CALL: assert property (
    i_ce && i_pc_op == PC_SHORT_CALL && !pcl_wr
    |=> o_push_valid && o_push_addr == $past(o_pc) + 10'h001
        && o_pc == {$past(st_ff.pc_high_buffer[1:0]), $past(i_insn_target[7:0])})
    else $error("short call wrong");
  AST_LONG_CALL: assert property (
    i_ce && i_pc_op == PC_LONG_CALL && !pcl_wr
    |=> o_push_valid && o_pc == $past(i_insn_target))
    else $error("long call wrong");
  AST_SLEEP_FLAGS: assert property (
    i_ce && i_sleep && !i_wdt_timeout
    |=> !st_ff.status[`BIT_POWER_DOWN] && st_ff.status[`BIT_TIMEOUT])
    else $error("sleep flags wrong");
  AST_TIMEOUT_FLAG: assert property (
    i_ce && i_wdt_timeout |=> !st_ff.status[`BIT_TIMEOUT])
    else $error("timeout flag not cleared");
  AST_RESET_VALUES: assert property (
    $fell(i_rst) |-> o_wake_enable == `RST_WAKE_CONTROL && o_watchdog_enable && o_lv_reset_enable)
    else $error("reset values wrong");

  COV_INDIRECT: cover property (i_ce && i_wr_en && i_addr == `OFF_INDIRECT_ACCESS_PORT);
  COV_CALL_PUSH: cover property (o_push_valid ##1 i_ce && i_pc_op == PC_LONG_JUMP);
  COV_SLEEP_THEN_TIMEOUT: cover property (i_ce && i_sleep ##[1:20] i_ce && i_wdt_timeout);

endmodule : core_special_register_bank
`default_nettype wire

// *** hdl/sfr_flag_unit.sv ***
/*
  Carry, half-carry and zero flag generation for one core operation.
  Assumes operands and the logic result are stable for the cycle of the update.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.svh"

module sfr_flag_unit (
  // Operation
  input wire core_sfr_pkg::flag_op_t i_op,
  input wire logic [7:0] i_opnd_a,
  input wire logic [7:0] i_opnd_b,
  input wire logic [7:0] i_logic_result,
  // Flags
  output logic o_update_arith,
  output logic o_update_zero,
  output logic o_carry,
  output logic o_half_carry,
  output logic o_zero
);
  import core_sfr_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib_sum;
  logic [7:0] result;

  // ==========================================================
  // Flag logic
  always_comb begin
    sum = {1'b0, i_opnd_a} + {1'b0, i_opnd_b};
    nib_sum = {1'b0, i_opnd_a[3:0]} + {1'b0, i_opnd_b[3:0]};
    o_update_arith = (i_op == FLAG_ADD) || (i_op == FLAG_SUB);
    o_update_zero = (i_op != FLAG_NONE);
    o_carry = 1'b0;
    o_half_carry = 1'b0;
    result = i_logic_result;
    case (i_op)
      FLAG_ADD: begin
        o_carry = sum[8];
        o_half_carry = nib_sum[`HALF_CARRY_POS];
        result = sum[7:0];
      end
      FLAG_SUB: begin
        // Carry set means no borrow was needed
        o_carry = (i_opnd_a >= i_opnd_b);
        o_half_carry = (i_opnd_a[3:0] >= i_opnd_b[3:0]);
        result = i_opnd_a - i_opnd_b;
      end
      default: begin
        result = i_logic_result;
      end
    endcase
    o_zero = (result == 8'h00);
  end

endmodule : sfr_flag_unit
`default_nettype wire

// *** sim/gpr_model.sv ***
/*
  Behavioural general register file beside the special register bank.
  Assumes the bank forwards select, address, strobe and data on i_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module gpr_model (
  // Clock
  input wire logic i_clk,
  // Forwarded access
  input wire logic i_sel,
  input wire logic [5:0] i_addr,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [64];
  logic [7:0] noise_ff;

  // ==========================================================
  // Storage
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    noise_ff = 8'h00;
  end

  always @(posedge i_clk) begin
    noise_ff <= noise_ff + 8'h3B;
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  // Unselected reads show a moving pattern so a stale value never passes
  assign o_rdata = i_sel ? mem[i_addr] : noise_ff;
endmodule : gpr_model

`default_nettype wire

// *** sim/tb.sv ***
/*
  Self-checking bench for the core special register bank.
  Assumes the defines header on the include path and the register file model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.svh"

module tb;
  import core_sfr_pkg::*;
  logic clk, rst, rd, wr, gsel, gwe, pv, slp, clr, wto, tick, ext, lf, src, lfsel, fall, allow, rlat;
  logic wde, lvd, lvr, eir, ce;
  logic [5:0] addr, gaddr, pin, isout, latch, wake;
  logic [7:0] wdata, rdata, gwdata, grdata, a, b, lr, t0;
  logic [9:0] tgt, pc, pa, ret;
  pc_op_t pop;
  flag_op_t fop;
  int n_fail = 0;
  int checks = 0;
  logic [5:0] rst_adr [7] = '{`OFF_TIMER0_COUNT, `OFF_PC_LOW_BYTE, `OFF_STATUS_FLAGS, `OFF_FILE_SELECT,
                              `OFF_POWER_CONTROL, `OFF_PORT_WAKE_CONTROL, `OFF_PC_HIGH_BUFFER};
  logic [7:0] rst_exp [7] = '{8'h00, 8'h00, 8'h18, 8'h00, 8'h88, 8'h3F, 8'h00};

  // ==========================================================
  // Design and register file model
  core_special_register_bank #(.ADDR_W(6)) DUT (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr), .i_rd_en(rd), .i_wr_en(wr),
    .i_wr_data(wdata), .o_rd_data(rdata), .o_gpr_sel(gsel), .o_gpr_addr(gaddr), .o_gpr_we(gwe),
    .o_gpr_wdata(gwdata), .i_gpr_rdata(grdata), .i_pc_op(pop), .i_insn_target(tgt),
    .i_ret_addr(ret), .o_pc(pc), .o_push_valid(pv), .o_push_addr(pa), .i_flag_op(fop),
    .i_opnd_a(a), .i_opnd_b(b), .i_logic_result(lr), .i_sleep(slp), .i_clrwdt(clr),
    .i_wdt_timeout(wto), .i_inst_tick(tick), .i_ext_timer_clk(ext), .i_lowfreq_clk(lf),
    .i_t0_ext_src(src), .i_t0_lowfreq_sel(lfsel), .i_t0_fall_edge(fall), .i_cfg_lowfreq_allow(allow),
    .o_timer0(t0), .i_pin_level(pin), .i_pin_is_output(isout), .i_cfg_read_latch(rlat),
    .o_port_latch(latch), .o_watchdog_enable(wde), .o_lv_detect_enable(lvd),
    .o_lv_reset_enable(lvr), .o_ext_int_route(eir), .o_wake_enable(wake)
  );

  gpr_model gpr (.i_clk(clk), .i_sel(gsel), .i_addr(gaddr), .i_we(gwe), .i_wdata(gwdata), .o_rdata(grdata));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] ad, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({2'h0, rdata & m}, {2'h0, exp & m});
  endtask : rd_reg

  task automatic pc_cmd(input pc_op_t op, input logic [9:0] t, input logic [9:0] epc, input logic epush,
                        input logic [9:0] epa);
    @(posedge clk);
    pop <= op;
    tgt <= t;
    @(posedge clk);
    pop <= PC_HOLD;
    #1;
    chk(pc, epc);
    chk({9'h0, pv}, {9'h0, epush});
    if (epush) chk(pa, epa);
  endtask : pc_cmd

  task automatic alu(input flag_op_t op, input logic [7:0] x, input logic [7:0] y);
    @(posedge clk);
    fop <= op;
    a <= x;
    b <= y;
    lr <= x & y;
    @(posedge clk);
    fop <= FLAG_NONE;
  endtask : alu

  task automatic ev(input logic [2:0] v);
    @(posedge clk);
    {slp, clr, wto} <= v;
    @(posedge clk);
    {slp, clr, wto} <= 3'h0;
  endtask : ev

  // Slow source: high two cycles, low three cycles between pulses, so each level is seen
  task automatic edges(input logic use_lf, input int n);
    repeat (n) begin
      @(posedge clk);
      {lf, ext} <= use_lf ? 2'b10 : 2'b01;
      repeat (2) @(posedge clk);
      {lf, ext} <= 2'b00;
      repeat (2) @(posedge clk);
    end
    #1;
  endtask : edges

  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {rd, wr, slp, clr, wto, tick, ext, lf, src, lfsel, fall, allow, rlat} = '0;
    {addr, wdata, a, b, lr, tgt, ret, pin, isout} = '0;
    ce = 1'b1;
    pop = PC_HOLD;
    fop = FLAG_NONE;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_reg(rst_adr[i], rst_exp[i], 8'hFF);
    chk({6'h0, wde, lvd, lvr, eir}, 10'h00A);
    chk({4'h0, wake}, 10'h03F);
    wr_reg(`OFF_POWER_CONTROL, 8'h67);
    chk({6'h0, wde, lvd, lvr, eir}, 10'h005);
    rd_reg(`OFF_POWER_CONTROL, 8'h67, 8'hFF);
    wr_reg(`OFF_PORT_WAKE_CONTROL, 8'hC5);
    chk({4'h0, wake}, 10'h005);
    rd_reg(`OFF_PORT_WAKE_CONTROL, 8'h05, 8'hFF);
    wr_reg(`OFF_STATUS_FLAGS, 8'hE0);
    rd_reg(`OFF_STATUS_FLAGS, 8'hE0, 8'hE0);
    wr_reg(`OFF_PC_HIGH_BUFFER, 8'hFE);
    rd_reg(`OFF_PC_HIGH_BUFFER, 8'h06, 8'hFF);
    // Indirect through a pointer with both bank bits set
    wr_reg(`OFF_FILE_SELECT, 8'hC1);
    wr_reg(`OFF_INDIRECT_ACCESS_PORT, 8'h5A);
    chk({2'h0, t0}, 10'h05A);
    rd_reg(`OFF_FILE_SELECT, 8'hC1, 8'hFF);
    wr_reg(`OFF_FILE_SELECT, 8'h20);
    wr_reg(`OFF_INDIRECT_ACCESS_PORT, 8'h33);
    rd_reg(`OFF_INDIRECT_ACCESS_PORT, 8'h33, 8'hFF);
    rd_reg(6'h20, 8'h33, 8'hFF);
    // Timer sources
    @(posedge clk);
    tick <= 1'b1;
    repeat (5) @(posedge clk);
    tick <= 1'b0;
    rd_reg(`OFF_TIMER0_COUNT, 8'h5F, 8'hFF);
    src <= 1'b1;
    edges(1'b0, 3);
    chk({2'h0, t0}, 10'h062);
    lfsel <= 1'b1;
    edges(1'b1, 2);
    chk({2'h0, t0}, 10'h062);
    allow <= 1'b1;
    fall <= 1'b1;
    edges(1'b1, 4);
    rd_reg(`OFF_TIMER0_COUNT, 8'h66, 8'hFF);
    // Clock enable low must freeze the count even against a write
    ce <= 1'b0;
    wr_reg(`OFF_TIMER0_COUNT, 8'hA5);
    chk({2'h0, t0}, 10'h066);
    ce <= 1'b1;
    // Port B
    pin <= 6'h15;
    isout <= 6'h0F;
    wr_reg(`OFF_PORT_B_DATA, 8'hEA);
    chk({4'h0, latch}, 10'h02A);
    rd_reg(`OFF_PORT_B_DATA, 8'hD5, 8'hFF);
    rlat <= 1'b1;
    rd_reg(`OFF_PORT_B_DATA, 8'hDA, 8'hFF);
    // Arithmetic flags
    alu(FLAG_ADD, 8'h0F, 8'h01);
    rd_reg(`OFF_STATUS_FLAGS, 8'h02, 8'h07);
    alu(FLAG_ADD, 8'hFF, 8'h01);
    rd_reg(`OFF_STATUS_FLAGS, 8'h07, 8'h07);
    alu(FLAG_SUB, 8'h10, 8'h01);
    rd_reg(`OFF_STATUS_FLAGS, 8'h01, 8'h07);
    alu(FLAG_LOGIC, 8'hF0, 8'h0F);
    rd_reg(`OFF_STATUS_FLAGS, 8'h05, 8'h07);
    alu(FLAG_SUB, 8'h01, 8'h02);
    rd_reg(`OFF_STATUS_FLAGS, 8'h00, 8'h07);
    // Power events
    ev(3'b100);
    rd_reg(`OFF_STATUS_FLAGS, 8'h10, 8'h18);
    ev(3'b001);
    rd_reg(`OFF_STATUS_FLAGS, 8'h00, 8'h18);
    ev(3'b010);
    rd_reg(`OFF_STATUS_FLAGS, 8'h18, 8'h18);
    // Program counter
    pc_cmd(PC_STEP, 10'h000, 10'h001, 1'b0, 10'h000);
    pc_cmd(PC_STEP, 10'h000, 10'h002, 1'b0, 10'h000);
    rd_reg(`OFF_PC_LOW_BYTE, 8'h02, 8'hFF);
    pc_cmd(PC_SHORT_JUMP, 10'h1AB, 10'h3AB, 1'b0, 10'h000);
    pc_cmd(PC_SHORT_CALL, 10'h155, 10'h255, 1'b1, 10'h3AC);
    pc_cmd(PC_LONG_JUMP, 10'h123, 10'h123, 1'b0, 10'h000);
    pc_cmd(PC_LONG_CALL, 10'h0F0, 10'h0F0, 1'b1, 10'h124);
    wr_reg(`OFF_PC_LOW_BYTE, 8'h77);
    chk(pc, 10'h277);
    rd_reg(`OFF_PC_LOW_BYTE, 8'h77, 8'hFF);
    ret <= 10'h1C4;
    pc_cmd(PC_RETURN, 10'h000, 10'h1C4, 1'b0, 10'h000);
    final_report();
  end
endmodule : tb

`default_nettype wire
